// >>> verilog/sep_defs.svh
// Constants of the serial word-memory command port.
// Assumes inclusion by bare name from the package and the design module.
`ifndef SEP_DEFS_SVH
`define SEP_DEFS_SVH
`define SEP_WORDS        16
`define SEP_WORD_W       16
`define SEP_ADDR_W       4
`define SEP_FRAME_BITS   4'h8
`define SEP_DATA_BITS    5'h10
`define SEP_ERASED_WORD  16'hFFFF
`define SEP_OP_READ      2'h2
`define SEP_OP_WRITE     2'h1
`define SEP_OP_ERASE     2'h3
`define SEP_OP_SPECIAL   2'h0
`define SEP_SUB_DISABLE  2'h0
`define SEP_SUB_WRALL    2'h1
`define SEP_SUB_ERALL    2'h2
`define SEP_SUB_ENABLE   2'h3
`endif

// >>> verilog/sep_pkg.sv
// Types of the serial word-memory command port.
// Assumes sep_defs.svh is on the include path.
`include "sep_defs.svh"
package sep_pkg;
  typedef enum logic [2:0] {
    SEP_IDLE  = 3'b000,
    SEP_START = 3'b001,
    SEP_INSTR = 3'b010,
    SEP_DATA  = 3'b011,
    SEP_READ  = 3'b100,
    SEP_ARMED = 3'b101,
    SEP_PROG  = 3'b110,
    SEP_DONE  = 3'b111
  } sep_state_t;

  typedef struct packed {
    logic [2:0]  sync_sk;
    logic [2:0]  sync_cs;
    logic [2:0]  sync_di;
    logic        sk_q;
    logic        cs_q;
    sep_state_t  state;
    logic [3:0]  cnt;
    logic [7:0]  instr;
    logic [15:0] wdata;
    logic [15:0] shift;
    logic [4:0]  rcnt;
    logic        dout;
    logic        doe;
    logic        prog_en;
    logic        hv_on;
  } sep_st_t;
endpackage : sep_pkg

// >>> verilog/sep_port.sv
// Serial command port and storage of a sixteen-word by sixteen-bit nonvolatile memory.
// Assumes the serial pins are asynchronous to sys_clk, slow (at most 200 kHz).
//
// Behaviour
// - Frame is start bits 0,1, four opcode bits, four address bits, serially.
// - Four address bits select one of sixteen 16-bit words.
// - Read 10xx, write 01xx, erase 11xx; low opcode bits ignored.
// - Code 0010 erases all; 0001 plus sixteen data bits writes all.
// - Code 0011 sets program enable latch, 0000 clears it; latch persists.
// - Read works whatever the enable latch holds.
// - Read loads word, drives dummy zero, then sixteen data bits.
// - Each data output change while driven launched by rising serial clock.
// - Data output driven only during read, otherwise released.
// - Select falling after a programming instruction starts programming if the enable latch is set.
// - Erase sets all sixteen bits of the word to one.
// - Write takes sixteen bits MSB first, clearing selected bits.
// - Programming lasts while select low; ends when select rises.
// - Serial clock may idle during the programming pulse.
// - High voltage generator active only while programming.
// - Write-all clears the same selected bits in every word at once.
// - Erase-all sets every bit of every word to one.
// - Select low without programming means low-power standby.
`timescale 1ns/10ps
`include "sep_defs.svh"
module sep_port (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic chip_select,
  input  wire logic serial_clock_in,
  input  wire logic serial_data_in,
  output logic      serial_data_out,
  output logic      serial_data_oe,
  output logic      prog_enabled,
  output logic      hv_active,
  output logic      standby
);

  sep_pkg::sep_st_t st_ff;
  sep_pkg::sep_st_t nxt_st;
  logic [15:0]      mem_ff [0:15];

  // ****************************************************************
  // Synchronised pin view
  // ****************************************************************
  logic sk_lvl;
  logic cs_lvl;
  logic di_lvl;
  logic sk_rise;
  logic cs_fall;
  logic cs_rise;
  logic [1:0] op;
  logic [3:0] addr;
  logic       wr_word;
  logic       wr_all;
  logic       clr_word;
  logic       clr_all;

  always_comb begin
    // A clock or select change counts once the second and third stages agree
    sk_lvl  = (st_ff.sync_sk[1] == st_ff.sync_sk[2]) ? st_ff.sync_sk[2] : st_ff.sk_q;
    cs_lvl  = (st_ff.sync_cs[1] == st_ff.sync_cs[2]) ? st_ff.sync_cs[2] : st_ff.cs_q;
    di_lvl  = st_ff.sync_di[2];
    sk_rise = sk_lvl & ~st_ff.sk_q;
    cs_fall = ~cs_lvl & st_ff.cs_q;
    cs_rise = cs_lvl & ~st_ff.cs_q;
    op      = st_ff.instr[7:6];
    addr    = st_ff.instr[3:0];
  end

  // ****************************************************************
  // Decoder, read shifter and programming control
  // ****************************************************************
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.sync_sk = {st_ff.sync_sk[1:0], serial_clock_in};
    nxt_st.sync_cs = {st_ff.sync_cs[1:0], chip_select};
    nxt_st.sync_di = {st_ff.sync_di[1:0], serial_data_in};
    nxt_st.sk_q    = sk_lvl;
    nxt_st.cs_q    = cs_lvl;
    case (st_ff.state)
      sep_pkg::SEP_IDLE: begin
        nxt_st.cnt = 4'h0;
        if (cs_lvl && sk_rise && !di_lvl) begin
          nxt_st.state = sep_pkg::SEP_START;
        end
      end
      sep_pkg::SEP_START: begin
        if (sk_rise) begin
          nxt_st.state = di_lvl ? sep_pkg::SEP_INSTR : sep_pkg::SEP_START;
        end
      end
      sep_pkg::SEP_INSTR: begin
        if (sk_rise) begin
          nxt_st.instr = {st_ff.instr[6:0], di_lvl};
          nxt_st.cnt   = st_ff.cnt + 4'h1;
          if (st_ff.cnt == `SEP_FRAME_BITS - 4'h1) begin
            nxt_st.cnt  = 4'h0;
            nxt_st.rcnt = 5'h0;
            case (st_ff.instr[6:5])
              `SEP_OP_READ: begin
                nxt_st.state = sep_pkg::SEP_READ;
                nxt_st.shift = mem_ff[{st_ff.instr[2:0], di_lvl}];
              end
              `SEP_OP_WRITE: nxt_st.state = sep_pkg::SEP_DATA;
              `SEP_OP_ERASE: nxt_st.state = sep_pkg::SEP_ARMED;
              default: begin
                case (st_ff.instr[4:3])
                  `SEP_SUB_ENABLE: begin
                    nxt_st.prog_en = 1'b1;
                    nxt_st.state   = sep_pkg::SEP_DONE;
                  end
                  `SEP_SUB_DISABLE: begin
                    nxt_st.prog_en = 1'b0;
                    nxt_st.state   = sep_pkg::SEP_DONE;
                  end
                  `SEP_SUB_WRALL: nxt_st.state = sep_pkg::SEP_DATA;
                  default:        nxt_st.state = sep_pkg::SEP_ARMED;
                endcase
              end
            endcase
          end
        end
      end
      sep_pkg::SEP_DATA: begin
        if (sk_rise) begin
          nxt_st.wdata = {st_ff.wdata[14:0], di_lvl};
          nxt_st.rcnt  = st_ff.rcnt + 5'h1;
          if (st_ff.rcnt == `SEP_DATA_BITS - 5'h1) begin
            nxt_st.state = sep_pkg::SEP_ARMED;
          end
        end
      end
      sep_pkg::SEP_READ: begin
        nxt_st.doe = 1'b1;
        if (sk_rise) begin
          if (st_ff.rcnt == 5'h0) begin
            nxt_st.dout = 1'b0;
          end else begin
            nxt_st.dout  = st_ff.shift[15];
            nxt_st.shift = {st_ff.shift[14:0], 1'b0};
          end
          if (st_ff.rcnt != `SEP_DATA_BITS + 5'h1) begin
            nxt_st.rcnt = st_ff.rcnt + 5'h1;
          end
        end
      end
      sep_pkg::SEP_ARMED: begin
        if (cs_fall) begin
          nxt_st.state = st_ff.prog_en ? sep_pkg::SEP_PROG : sep_pkg::SEP_IDLE;
          nxt_st.hv_on = st_ff.prog_en;
        end
      end
      sep_pkg::SEP_PROG: begin
        if (cs_rise) begin
          nxt_st.hv_on = 1'b0;
          nxt_st.state = sep_pkg::SEP_IDLE;
        end
      end
      sep_pkg::SEP_DONE: nxt_st.state = sep_pkg::SEP_DONE;
      default:           nxt_st.state = sep_pkg::SEP_IDLE;
    endcase
    if (!cs_lvl && st_ff.state != sep_pkg::SEP_ARMED && st_ff.state != sep_pkg::SEP_PROG) begin
      nxt_st.state = sep_pkg::SEP_IDLE;
      nxt_st.doe   = 1'b0;
      nxt_st.dout  = 1'b0;
    end
    if (st_ff.state == sep_pkg::SEP_ARMED && cs_fall && !st_ff.prog_en) begin
      nxt_st.hv_on = 1'b0;
    end
  end

  // ****************************************************************
  // State and storage registers
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_ff       <= '0;
      st_ff.state <= sep_pkg::SEP_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Word updates repeat on every cycle of the pulse; both are idempotent
  always_comb begin
    wr_word  = st_ff.hv_on && (op == `SEP_OP_WRITE) && st_ff.state == sep_pkg::SEP_PROG;
    clr_word = st_ff.hv_on && (op == `SEP_OP_ERASE) && st_ff.state == sep_pkg::SEP_PROG;
    wr_all   = st_ff.hv_on && (op == `SEP_OP_SPECIAL) && st_ff.instr[5:4] == `SEP_SUB_WRALL;
    clr_all  = st_ff.hv_on && (op == `SEP_OP_SPECIAL) && st_ff.instr[5:4] == `SEP_SUB_ERALL;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `SEP_WORDS; gi++) begin : g_word
      always_ff @(posedge sys_clk) begin
        if (clr_all || (clr_word && addr == 4'(gi))) begin
          mem_ff[gi] <= `SEP_ERASED_WORD;
        end else if (wr_all || (wr_word && addr == 4'(gi))) begin
          mem_ff[gi] <= mem_ff[gi] & st_ff.wdata;
        end
      end
    end
  endgenerate

  assign serial_data_out = st_ff.dout;
  assign serial_data_oe  = st_ff.doe;
  assign prog_enabled    = st_ff.prog_en;
  assign hv_active       = st_ff.hv_on;
  assign standby         = !st_ff.cs_q && !st_ff.hv_on;

  // ****************************************************************
  // Checks
  // ****************************************************************
  oe_read_only_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    serial_data_oe |-> $past(st_ff.state) == sep_pkg::SEP_READ)
    else $error("data output driven outside read");
  hv_needs_en_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(hv_active) |-> $past(prog_enabled))
    else $error("high voltage without enable");
  hv_ends_cs_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    (hv_active && cs_rise) |=> !hv_active)
    else $error("programming did not end on select rise");
  dout_on_sk_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    ($changed(serial_data_out) && serial_data_oe && $past(serial_data_oe)) |-> $past(sk_rise))
    else $error("output changed without clock rise");
  dummy_zero_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st_ff.state == sep_pkg::SEP_READ && st_ff.rcnt == 5'h1) |-> !serial_data_out)
    else $error("dummy bit not zero");
  erase_ones_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    clr_word |=> mem_ff[$past(addr)] == `SEP_ERASED_WORD)
    else $error("erased word not all ones");
  enable_latch_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(prog_enabled) |-> $past(st_ff.state) == sep_pkg::SEP_INSTR)
    else $error("enable latch cleared without command");
  abort_idle_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!cs_lvl && st_ff.state == sep_pkg::SEP_INSTR) |=> st_ff.state == sep_pkg::SEP_IDLE)
    else $error("partial frame not aborted");

  // ****************************************************************
  // Decoder and storage checks
  // ****************************************************************
  prog_start_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st_ff.state == sep_pkg::SEP_ARMED && cs_fall && st_ff.prog_en)
    |=> hv_active)
    else $error("programming did not start on select fall");
  locked_no_hv_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st_ff.state == sep_pkg::SEP_ARMED && cs_fall && !st_ff.prog_en)
    |=> (!hv_active && st_ff.state == sep_pkg::SEP_IDLE))
    else $error("locked programming was not refused");
  idle_oe_off_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st_ff.state == sep_pkg::SEP_IDLE)
    |-> !serial_data_oe)
    else $error("data output driven while idle");
  hv_only_prog_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    hv_active
    |-> (st_ff.state == sep_pkg::SEP_PROG))
    else $error("high voltage outside programming");
  read_load_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st_ff.state == sep_pkg::SEP_INSTR && sk_rise && cs_lvl && st_ff.instr[6:5] == `SEP_OP_READ
     && st_ff.cnt == `SEP_FRAME_BITS - 4'h1)
    |=> st_ff.shift == $past(mem_ff[{st_ff.instr[2:0], di_lvl}]))
    else $error("read did not load addressed word");
  erase_all_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    clr_all
    |=> (mem_ff[0] == `SEP_ERASED_WORD && mem_ff[15] == `SEP_ERASED_WORD))
    else $error("erase all left a word not all ones");
  write_and_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_word
    |=> mem_ff[$past(addr)] == ($past(mem_ff[addr]) & $past(st_ff.wdata)))
    else $error("write did not clear selected bits");
  write_all_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_all
    |=> mem_ff[0] == ($past(mem_ff[0]) & $past(st_ff.wdata)))
    else $error("write all did not load pattern");
  latch_set_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(prog_enabled)
    |-> $past(st_ff.state) == sep_pkg::SEP_INSTR)
    else $error("enable latch set without command");
  start_bits_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st_ff.state == sep_pkg::SEP_START && sk_rise && di_lvl && cs_lvl)
    |=> st_ff.state == sep_pkg::SEP_INSTR)
    else $error("start bit one not accepted");
  standby_hv_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    standby
    |-> (!hv_active && !st_ff.cs_q))
    else $error("standby during programming or select");
  data_count_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st_ff.state == sep_pkg::SEP_DATA && sk_rise && cs_lvl && st_ff.rcnt == 5'hF)
    |=> st_ff.state == sep_pkg::SEP_ARMED)
    else $error("data field not sixteen bits");
  prog_hold_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st_ff.state == sep_pkg::SEP_PROG && !cs_rise)
    |=> st_ff.state == sep_pkg::SEP_PROG)
    else $error("programming ended before select rise");
  read_shift_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st_ff.state == sep_pkg::SEP_READ && sk_rise && cs_lvl && st_ff.rcnt != 5'h0)
    |=> serial_data_out == $past(st_ff.shift[15]))
    else $error("read bit out of order");
  abort_start_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!cs_lvl && st_ff.state == sep_pkg::SEP_START)
    |=> st_ff.state == sep_pkg::SEP_IDLE)
    else $error("start bit wait not aborted");

endmodule : sep_port

// >>> testbench/sep_host_model.sv
// Controller model that drives the select, serial clock and data lines.
// Assumes sys_clk paces the lines; one serial half period is HALF cycles.
`timescale 1ns/10ps
module sep_host_model (
  input  wire logic sys_clk,
  output logic      chip_select,
  output logic      serial_clock_in,
  output logic      serial_data_in,
  input  wire logic serial_data_out,
  input  wire logic serial_data_oe
);
  // ****************************************
  // Serial line sequencing
  // ****************************************
  localparam int HALF = 8;
  initial begin
    chip_select = 1'b0;
    serial_clock_in = 1'b0;
    serial_data_in = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt
  // Serial clock stays idle while select sits; pulse is timed by select
  task automatic sel(input logic v);
    @(posedge sys_clk);
    chip_select <= v;
    serial_clock_in <= 1'b0;
    wt(2 * HALF);
  endtask : sel
  // Data changes with the fall, is taken on the rise
  task automatic bit1(input logic b, output logic q);
    serial_clock_in <= 1'b0;
    serial_data_in <= b;
    wt(HALF);
    serial_clock_in <= 1'b1;
    wt(HALF);
    q = serial_data_out;
  endtask : bit1
  task automatic cmd(input logic [3:0] op, a, input logic [15:0] d, input int nd);
    logic       q;
    logic [9:0] v;
    v = {2'b01, op, a};
    sel(1'b1);
    for (int i = 9; i >= 0; i--) bit1(v[i], q);
    for (int i = nd - 1; i >= 0; i--) bit1(d[i], q);
  endtask : cmd
  task automatic rd(input logic [3:0] op, a, output logic [15:0] d, output logic dm, ok);
    logic q;
    cmd(op, a, 16'h0000, 0);
    ok = 1'b1;
    for (int i = 0; i < 17; i++) begin
      bit1(1'b0, q);
      ok &= serial_data_oe;
      if (i == 0) dm = q;
      else d = {d[14:0], q};
    end
    sel(1'b0);
  endtask : rd
endmodule : sep_host_model

// >>> testbench/test_serial_eeprom_16x16_port.sv
// Self-checking bench for the serial word-memory command port.
// Assumes sep_host_model drives the serial lines; programming pulses are shortened.
`timescale 1ns/10ps
module test_serial_eeprom_16x16_port;
  // ****************************************
  // Harness
  // ****************************************
  logic sys_clk = 1'b0;
  logic rst_b   = 1'b0;
  logic chip_select;
  logic serial_clock_in;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_oe;
  logic prog_enabled;
  logic hv_active;
  logic standby;
  int   fails    = 0;
  int   n_checks = 0;
  int   cyc      = 0;
  always #4 sys_clk = ~sys_clk;
  sep_port DUT (.sys_clk(sys_clk), .rst_b(rst_b), .chip_select(chip_select),
    .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
    .prog_enabled(prog_enabled), .hv_active(hv_active), .standby(standby));
  sep_host_model host (.sys_clk(sys_clk), .chip_select(chip_select),
    .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe));
  task automatic final_report;
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      final_report;
    end
  end
  task automatic check(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic prog(input logic [3:0] op, a, input logic [15:0] d, input int nd,
                      input logic hv);
    host.cmd(op, a, d, nd);
    check("oe_in_cmd", {15'h0, serial_data_oe}, 16'h0000);
    host.sel(1'b0);
    check("hv_active", {15'h0, hv_active}, {15'h0, hv});
    check("standby", {15'h0, standby}, {15'h0, ~hv});
    host.sel(1'b1);
    check("hv_end", {15'h0, hv_active}, 16'h0000);
    host.sel(1'b0);
  endtask : prog
  task automatic rd(input logic [3:0] op, a, input logic [15:0] exp);
    logic [15:0] d;
    logic        dm;
    logic        ok;
    host.rd(op, a, d, dm, ok);
    check("read_data", d, exp);
    check("dummy_bit", {15'h0, dm}, 16'h0000);
    check("read_oe", {15'h0, ok}, 16'h0001);
    check("idle_oe", {15'h0, serial_data_oe}, 16'h0000);
  endtask : rd
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_erase_all;
    prog(4'h3, 4'h0, 16'h0000, 0, 1'b0);
    check("latch_on", {15'h0, prog_enabled}, 16'h0001);
    prog(4'h2, 4'h5, 16'h0000, 0, 1'b1);
    rd(4'h8, 4'h0, 16'hFFFF);
    rd(4'hB, 4'h9, 16'hFFFF);
  endtask : t_erase_all
  task automatic t_write;
    prog(4'h6, 4'h3, 16'hA5C3, 16, 1'b1);
    rd(4'h9, 4'h3, 16'hA5C3);
    rd(4'hA, 4'h4, 16'hFFFF);
  endtask : t_write
  task automatic t_locked;
    prog(4'h0, 4'h0, 16'h0000, 0, 1'b0);
    check("latch_off", {15'h0, prog_enabled}, 16'h0000);
    prog(4'hC, 4'h3, 16'h0000, 0, 1'b0);
    prog(4'h1, 4'h0, 16'h0000, 16, 1'b0);
    rd(4'h8, 4'h3, 16'hA5C3);
    rd(4'h8, 4'h4, 16'hFFFF);
  endtask : t_locked
  task automatic t_write_all;
    prog(4'h3, 4'h0, 16'h0000, 0, 1'b0);
    prog(4'h2, 4'h0, 16'h0000, 0, 1'b1);
    prog(4'h1, 4'h7, 16'h0F0F, 16, 1'b1);
    rd(4'h8, 4'h0, 16'h0F0F);
    rd(4'h8, 4'hF, 16'h0F0F);
  endtask : t_write_all
  task automatic t_erase_one;
    prog(4'hD, 4'hF, 16'h0000, 0, 1'b1);
    rd(4'h8, 4'hF, 16'hFFFF);
    rd(4'h8, 4'h0, 16'h0F0F);
  endtask : t_erase_one
  // Partial erase frame cut short by select
  task automatic t_abort;
    logic q;
    host.sel(1'b1);
    host.bit1(1'b0, q);
    host.bit1(1'b1, q);
    host.bit1(1'b1, q);
    host.bit1(1'b1, q);
    host.sel(1'b0);
    check("abort_hv", {15'h0, hv_active}, 16'h0000);
    rd(4'h8, 4'h0, 16'h0F0F);
  endtask : t_abort
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    host.wt(4);
    t_erase_all;
    t_write;
    t_locked;
    t_write_all;
    t_erase_one;
    t_abort;
    final_report;
  end
endmodule : test_serial_eeprom_16x16_port
